// file: core/tbw_host.sv
// Purpose: Host controller driving a self-timed byte-write memory by pins.
// Assumes: One request at a time; fast_mode chosen per device variant.
// Notes: Ready/busy is polled, with the full write time as fallback.
`timescale 1ns/1ns
module tbw_host (
   input wire logic clk,
   input wire logic rst,
   input wire logic fast_mode,
   input wire logic req_valid,
   input wire tbw_pkg::tbw_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [tbw_pkg::DATA_W-1:0] rsp_rdata,
   output logic rsp_timeout,
   output tbw_pkg::tbw_pins_t pins,
   input wire logic [tbw_pkg::DATA_W-1:0] dq_i,
   input wire logic rdy_i
);
   // ----------------------------------------------------------------
   // State and storage.
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_WSET = 8'b0000_0010,
      ST_WPUL = 8'b0000_0100,
      ST_WHLD = 8'b0000_1000,
      ST_BUSY = 8'b0001_0000,
      ST_RECV = 8'b0010_0000,
      ST_READ = 8'b0100_0000,
      ST_RDON = 8'b1000_0000
   } tbw_state_t;
   tbw_state_t state_reg, state_next;
   logic [tbw_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic [tbw_pkg::CNT_W-1:0] elapsed_reg, elapsed_next;
   logic seen_busy_reg, seen_busy_next;
   tbw_pkg::tbw_pins_t pins_reg, pins_next;
   logic ready_reg, ready_next;
   logic rvalid_reg, rvalid_next;
   logic tmo_reg, tmo_next;
   logic [tbw_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic [tbw_pkg::DATA_W-1:0] dq_s;
   logic rdy_s;
   logic [tbw_pkg::CNT_W-1:0] wc_cyc;
   // ----------------------------------------------------------------
   // Pin synchronisers.
   // ----------------------------------------------------------------
   tbw_sync #(.W(tbw_pkg::DATA_W), .INIT(8'h00)) u_dq_sync (
      .clk(clk),
      .rst(rst),
      .d(dq_i),
      .q(dq_s)
   );
   tbw_sync #(.W(1), .INIT(1'b1)) u_rdy_sync (
      .clk(clk),
      .rst(rst),
      .d(rdy_i),
      .q(rdy_s)
   );
   assign wc_cyc = fast_mode ? tbw_pkg::CNT_W'(tbw_pkg::FAST_CYC)
                             : tbw_pkg::CNT_W'(tbw_pkg::STD_CYC);
   // ----------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      elapsed_next = elapsed_reg;
      seen_busy_next = seen_busy_reg;
      pins_next = pins_reg;
      ready_next = 1'b0;
      rvalid_next = 1'b0;
      tmo_next = tmo_reg;
      rdata_next = rdata_reg;
      if (cnt_reg != tbw_pkg::CNT_ZERO) begin
         cnt_next = cnt_reg - 1'b1;
      end
      unique case (state_reg)
         ST_IDLE: begin
            ready_next = 1'b1;
            if (req_valid && ready_reg) begin
               ready_next = 1'b0;
               pins_next.addr = req.addr;
               pins_next.ce_n = 1'b0;
               if (req.write) begin
                  pins_next.oe_n = 1'b1;
                  pins_next.dq_o = req.wdata;
                  pins_next.dq_oe = 1'b1;
                  cnt_next = tbw_pkg::CNT_W'(tbw_pkg::SETUP_CYC);
                  state_next = ST_WSET;
               end else begin
                  pins_next.we_n = 1'b1;
                  pins_next.oe_n = 1'b0;
                  pins_next.dq_oe = 1'b0;
                  cnt_next = tbw_pkg::CNT_W'(tbw_pkg::READ_CYC);
                  state_next = ST_READ;
               end
            end
         end
         ST_WSET: begin
            if (cnt_reg == tbw_pkg::CNT_ZERO) begin
               pins_next.we_n = 1'b0;
               cnt_next = tbw_pkg::CNT_W'(tbw_pkg::WR_PULSE_CYC);
               state_next = ST_WPUL;
            end
         end
         ST_WPUL: begin
            if (cnt_reg == tbw_pkg::CNT_ZERO) begin
               pins_next.we_n = 1'b1;
               cnt_next = tbw_pkg::CNT_W'(tbw_pkg::HOLD_CYC);
               state_next = ST_WHLD;
            end
         end
         ST_WHLD: begin
            if (cnt_reg == tbw_pkg::CNT_ZERO) begin
               pins_next.ce_n = 1'b1;
               pins_next.dq_oe = 1'b0;
               elapsed_next = tbw_pkg::CNT_ZERO;
               seen_busy_next = 1'b0;
               state_next = ST_BUSY;
            end
         end
         ST_BUSY: begin
            elapsed_next = elapsed_reg + 1'b1;
            if (!rdy_s) begin
               seen_busy_next = 1'b1;
            end
            if ((seen_busy_reg && rdy_s) || elapsed_reg >= wc_cyc) begin
               tmo_next = !seen_busy_reg;
               cnt_next = tbw_pkg::CNT_W'(tbw_pkg::RECOVERY_CYC);
               state_next = ST_RECV;
            end
         end
         ST_RECV: begin
            if (cnt_reg == tbw_pkg::CNT_ZERO) begin
               rvalid_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_READ: begin
            if (cnt_reg == tbw_pkg::CNT_ZERO) begin
               rdata_next = dq_s;
               tmo_next = 1'b0;
               pins_next.oe_n = 1'b1;
               pins_next.ce_n = 1'b1;
               state_next = ST_RDON;
            end
         end
         ST_RDON: begin
            rvalid_next = 1'b1;
            state_next = ST_IDLE;
         end
      endcase
   end
   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= tbw_pkg::CNT_ZERO;
         elapsed_reg <= tbw_pkg::CNT_ZERO;
         seen_busy_reg <= 1'b0;
         pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        addr: 13'h0000, dq_o: 8'h00, dq_oe: 1'b0};
         ready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         tmo_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         elapsed_reg <= elapsed_next;
         seen_busy_reg <= seen_busy_next;
         pins_reg <= pins_next;
         ready_reg <= ready_next;
         rvalid_reg <= rvalid_next;
         tmo_reg <= tmo_next;
         rdata_reg <= rdata_next;
      end
   end
   assign pins = pins_reg;
   assign req_ready = ready_reg;
   assign rsp_valid = rvalid_reg;
   assign rsp_rdata = rdata_reg;
   assign rsp_timeout = tmo_reg;
endmodule : tbw_host

// file: core/tbw_sync.sv
// Purpose: Two-flop synchroniser for an asynchronous pin level.
// Assumes: Single clock domain on the reading side.
// Notes: Only the second stage is read by other logic.
`timescale 1ns/1ns
module tbw_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : tbw_sync

// file: pkg/tbw_pkg.sv
// Purpose: Shared constants and carrier types for the byte-wide memory host.
// Assumes: 100 MHz clock, 8K x 8 device, open-drain ready/busy line.
// Notes: Times are kept in their own units; cycle counts derive from them.
package tbw_pkg;
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int COL_W = 5;
   // Timing figures in ns or us, as printed.
   localparam int WR_PULSE_NS = 150;
   localparam int NOISE_PULSE_NS = 20;
   localparam int SETUP_NS = 10;
   localparam int HOLD_NS = 70;
   localparam int READ_ACCESS_NS = 350;
   localparam int BUSY_ASSERT_DELAY_NS = 120;
   localparam int READ_RECOVERY_DELAY_US = 10;
   localparam int LATE_DATA_LIMIT_US = 1;
   localparam int BYTE_PROGRAM_DURATION_STD_US = 10000;
   localparam int BYTE_PROGRAM_DURATION_FAST_US = 2000;
   // Cycle counts: least times round up.
   localparam int WR_PULSE_CYC = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + 2;
   localparam int BUSY_WAIT_CYC =
      (BUSY_ASSERT_DELAY_NS * CLK_MHZ + 999) / 1000 + 3;
   localparam int RECOVERY_CYC = READ_RECOVERY_DELAY_US * CLK_MHZ;
   localparam int STD_CYC = BYTE_PROGRAM_DURATION_STD_US * CLK_MHZ;
   localparam int FAST_CYC = BYTE_PROGRAM_DURATION_FAST_US * CLK_MHZ;
   localparam int CNT_W = 21;
   localparam logic [CNT_W-1:0] CNT_ZERO = 21'h00_0000;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_o;
      logic dq_oe;
   } tbw_pins_t;
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tbw_req_t;
endpackage : tbw_pkg

// file: verification/tbw_host_assertions.sv
// Purpose: Port checks for the byte-write memory host.
// Assumes: Only the ports of the host are visible.
// Notes: Bound into every instance of the host.
`timescale 1ns/1ns
module tbw_host_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic rsp_valid,
   input wire tbw_pkg::tbw_pins_t pins,
   input wire logic rdy_i
);
   logic [4:0] low_reg;
   logic [4:0] low_next;
   logic [10:0] rec_reg;
   logic [10:0] rec_next;
   logic rdy_reg;
   always_comb begin
      low_next = pins.we_n ? 5'h00 : low_reg + 5'h01;
      rec_next = (rdy_i && !rdy_reg) ? 11'h000 :
         (rec_reg == 11'h7FF) ? rec_reg : rec_reg + 11'h001;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_reg <= 5'h00;
         rec_reg <= 11'h7FF;
         rdy_reg <= 1'b1;
      end else begin
         low_reg <= low_next;
         rec_reg <= rec_next;
         rdy_reg <= rdy_i;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_strobe_width: assert property ($rose(pins.we_n) |->
      low_reg >= 5'h0F)
      else $error("write strobe pulse too short");
   a_write_setup: assert property ($fell(pins.we_n) |->
      $past(pins.ce_n, 2) == 1'b0 && $past(pins.dq_oe, 2))
      else $error("select or data late before strobe");
   a_write_mode: assert property (!pins.we_n |->
      !pins.ce_n && pins.oe_n && pins.dq_oe)
      else $error("strobe low outside write mode");
   a_data_stable: assert property (!pins.we_n |=>
      $stable(pins.dq_o) && $stable(pins.addr))
      else $error("data or address moved during strobe");
   a_read_strobe: assert property (!pins.oe_n |-> pins.we_n)
      else $error("strobe low during read");
   a_busy_hold: assert property (!rdy_i && pins.ce_n |=> pins.ce_n)
      else $error("access started while busy");
   a_read_recovery: assert property ($fell(pins.ce_n) |->
      rec_reg >= 11'h3E8)
      else $error("access before recovery time");
   a_single_rsp: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   c_write: cover property ($rose(pins.we_n));
   c_read: cover property ($fell(pins.oe_n));
   c_busy_end: cover property ($rose(rdy_i));
endmodule : tbw_host_assertions

bind tbw_host tbw_host_assertions u_chk (.clk(clk), .rst(rst),
   .rsp_valid(rsp_valid), .pins(pins), .rdy_i(rdy_i));

// file: verification/tbw_host_tb.sv
// Purpose: Self-checking bench for the byte-write memory host.
// Assumes: Memory model with a shortened write time.
// Notes: Pin timing is judged by the bound checker.
`timescale 1ns/1ns
module tbw_host_tb;
   localparam int PROG_NS = 3000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fast_mode = 1'b0;
   logic req_valid = 1'b0;
   tbw_pkg::tbw_req_t req = '0;
   logic req_ready;
   logic rsp_valid;
   logic rsp_timeout;
   logic [7:0] rsp_rdata;
   logic [7:0] dq_i;
   logic [7:0] m_dout;
   logic [7:0] dq_last = 8'h00;
   logic m_en;
   logic m_busy;
   logic rdy_i;
   tbw_pkg::tbw_pins_t pins;
   int failures = 0;
   int cmp_count = 0;
   always #5 clk = ~clk;
   assign rdy_i = m_busy ? 1'b0 : 1'b1;
   assign dq_i = pins.dq_oe ? pins.dq_o : (m_en ? m_dout : ~dq_last);
   // A released data bus shows the inverse of its last driven value.
   always @(posedge clk) begin
      if (pins.dq_oe === 1'b1 || m_en === 1'b1) begin
         dq_last <= dq_i;
      end
   end
   tbw_host dut (.clk(clk), .rst(rst), .fast_mode(fast_mode),
      .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_timeout(rsp_timeout), .pins(pins), .dq_i(dq_i), .rdy_i(rdy_i));
   tbw_mem_model #(.PROG_NS(PROG_NS)) mem (.ce_n(pins.ce_n),
      .oe_n(pins.oe_n), .we_n(pins.we_n), .addr(pins.addr), .din(dq_i),
      .dout(m_dout), .dout_en(m_en), .busy_low(m_busy));
   task automatic chk_eq(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_eq
   task automatic chk_min(input int got, input int lo);
      cmp_count++;
      if (got < lo) begin
         failures++;
         $display("BAD %0t took %0d cycles, under %0d", $time, got, lo);
      end
   endtask : chk_min
   task automatic do_req(input logic w, input logic [12:0] a,
         input logic [7:0] d, output int n);
      req = '{write: w, addr: a, wdata: d};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 5000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_min(5000, n + 1);
      repeat (2) @(posedge clk);
      #1;
   endtask : do_req
   // Top address written, rewritten and read back.
   task automatic sc_overwrite;
      int n;
      do_req(1'b1, 13'h1FFF, 8'hA5, n);
      chk_min(n, PROG_NS / 10 + tbw_pkg::RECOVERY_CYC);
      chk_eq({7'h00, rsp_timeout}, 8'h00);
      do_req(1'b0, 13'h1FFF, 8'h00, n);
      chk_eq(rsp_rdata, 8'hA5);
      do_req(1'b1, 13'h1FFF, 8'h5A, n);
      do_req(1'b0, 13'h1FFF, 8'h00, n);
      chk_eq(rsp_rdata, 8'h5A);
   endtask : sc_overwrite
   // Fast variant across a row boundary, plus an erased byte.
   task automatic sc_fast;
      int n;
      fast_mode = 1'b1;
      do_req(1'b1, 13'h001F, 8'h3C, n);
      chk_eq({7'h00, rsp_timeout}, 8'h00);
      do_req(1'b1, 13'h0020, 8'hC3, n);
      do_req(1'b0, 13'h001F, 8'h00, n);
      chk_eq(rsp_rdata, 8'h3C);
      do_req(1'b0, 13'h0020, 8'h00, n);
      chk_eq(rsp_rdata, 8'hC3);
      do_req(1'b0, 13'h0A5A, 8'h00, n);
      chk_eq(rsp_rdata, 8'hFF);
      fast_mode = 1'b0;
   endtask : sc_fast
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      sc_overwrite();
      sc_fast();
      conclude();
   end
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      conclude();
   end
endmodule : tbw_host_tb

// file: verification/tbw_mem_model.sv
// Purpose: Behavioural byte-write memory facing the host.
// Assumes: Supply always good; write time shortened by PROG_NS.
// Notes: Ready/busy is an open-drain pull-down enable.
`timescale 1ns/1ns
module tbw_mem_model #(
   parameter int PROG_NS = 3000
) (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [12:0] addr,
   input wire logic [7:0] din,
   output logic [7:0] dout,
   output logic dout_en,
   output logic busy_low
);
   logic [7:0] mem [0:8191];
   logic [12:0] a_lat;
   logic [7:0] d_lat;
   logic armed;
   logic sel;
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      armed = 1'b0;
      busy_low = 1'b0;
   end
   assign sel = !ce_n && oe_n && !we_n;
   assign dout_en = !ce_n && !oe_n && we_n;
   assign dout = mem[addr];
   always @(negedge we_n) armed = 1'b1;
   always @(posedge sel) begin
      a_lat = addr;
      #20;
      if (sel && armed && !busy_low) busy_low = 1'b1;
   end
   always @(negedge sel) begin
      if (busy_low) begin
         d_lat = din;
         mem[a_lat] = 8'hFF;
         #(PROG_NS);
         mem[a_lat] = d_lat;
         busy_low = 1'b0;
      end
   end
endmodule : tbw_mem_model
